// *** rtl/serial_flash_read_erase_cmds.sv ***
`timescale 1ns/100ps
`include "flash_cmd_map.svh"
module serial_flash_read_erase_cmds
  import flash_seq_pkg::*;
#(
  parameter int AW = `MEM_AW,
  parameter int SMALL_BYTES = `SMALL_BLOCK_BYTES,
  parameter int BLOCK_BYTES = `BLOCK_BYTES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic io0_i,
  output logic io0_o,
  output logic io0_oe_n_o,
  input wire logic io1_i,
  output logic io1_o,
  output logic io1_oe_n_o,
  output logic busy_o,
  output logic wel_o
);
  localparam int LW = $clog2(BLOCK_BYTES) + 1;
  localparam logic [AW-1:0] SMALL_MASK = AW'(SMALL_BYTES - 1);
  localparam logic [AW-1:0] BLOCK_MASK = AW'(BLOCK_BYTES - 1);

  // Opcode byte to command kind
  function automatic cmd_e decode_op(input logic [7:0] op);
    cmd_e c;
    c = UNKNOWN_CMD;
    if (op == `OP_WRITE_DISABLE) c = WRITE_DISABLE_CMD;
    else if (op == `OP_WRITE_ENABLE) c = WRITE_ENABLE_CMD;
    else if (op == `OP_LOW_POWER_READ) c = LOW_POWER_READ_CMD;
    else if (op == `OP_FAST_READ) c = FAST_READ_CMD;
    else if (op == `OP_DUAL_OUT_READ) c = DUAL_OUTPUT_READ_CMD;
    else if (op == `OP_DUAL_IO_READ) c = DUAL_ADDR_DATA_READ_CMD;
    else if (op == `OP_CLEAR_4K_A || op == `OP_CLEAR_4K_B) c = SMALL_BLOCK_CLEAR_4K;
    else if (op == `OP_CLEAR_64K) c = BLOCK_CLEAR_64K;
    return c;
  endfunction

  function automatic logic [5:0] hdr_len(input cmd_e c);
    logic [5:0] n;
    n = `RISE_CNT_MAX;
    case (c)
      LOW_POWER_READ_CMD: n = `LOW_POWER_HDR;
      FAST_READ_CMD: n = `FAST_HDR;
      DUAL_OUTPUT_READ_CMD: n = `FAST_HDR;
      DUAL_ADDR_DATA_READ_CMD: n = `DUAL_IO_HDR;
      default: n = `RISE_CNT_MAX;
    endcase
    return n;
  endfunction

  function automatic logic is_dual(input cmd_e c);
    return (c == DUAL_OUTPUT_READ_CMD) || (c == DUAL_ADDR_DATA_READ_CMD);
  endfunction

  function automatic logic is_read(input cmd_e c);
    return (c == LOW_POWER_READ_CMD) || (c == FAST_READ_CMD) || is_dual(c);
  endfunction

  array_if #(.AW(AW)) arr_if ();

  flash_byte_array #(.AW(AW)) u_array (
    .clk_i(clk_i),
    .port_if(arr_if.mem)
  );

  // Pin synchronisers; stage 0 feeds only stage 1
  logic [2:0] cs_sync_reg;
  logic [2:0] sck_sync_reg;
  logic [1:0] io0_sync_reg;
  logic [1:0] io1_sync_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_sync_reg <= 3'h7;
      sck_sync_reg <= 3'h0;
      io0_sync_reg <= 2'h0;
      io1_sync_reg <= 2'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n_i};
      sck_sync_reg <= {sck_sync_reg[1:0], sck_i};
      io0_sync_reg <= {io0_sync_reg[0], io0_i};
      io1_sync_reg <= {io1_sync_reg[0], io1_i};
    end
  end

  logic cs_hi;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic bit0;
  logic bit1;
  assign cs_hi = cs_sync_reg[1];
  assign cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
  assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
  assign sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
  assign bit0 = io0_sync_reg[1];
  assign bit1 = io1_sync_reg[1];

  // Frame state
  logic [5:0] rise_cnt_reg, rise_cnt_next;
  logic [6:0] op_sh_reg, op_sh_next;
  cmd_e cmd_reg, cmd_next;
  logic [23:0] addr_reg, addr_next;
  logic [AW-1:0] rd_addr_reg, rd_addr_next;
  logic [7:0] out_sh_reg, out_sh_next;
  logic [2:0] out_left_reg, out_left_next;
  logic io0_reg, io0_next;
  logic io1_reg, io1_next;
  logic io0_oe_n_reg, io0_oe_n_next;
  logic io1_oe_n_reg, io1_oe_n_next;
  logic wel_reg, wel_next;
  logic busy_reg, busy_next;
  logic write_enable_cmd_go;
  logic write_disable_cmd_go;
  logic erase_go;
  logic er_last;
  logic data_fall;
  logic load_ev;

  assign data_fall = !cs_hi && sck_fall && is_read(cmd_reg) && !busy_reg &&
                     (rise_cnt_reg >= hdr_len(cmd_reg));
  assign load_ev = data_fall && (out_left_reg == 3'h0);

  // Next values of the frame decoder, shifter and latch
  always_comb begin
    rise_cnt_next = rise_cnt_reg;
    op_sh_next = op_sh_reg;
    cmd_next = cmd_reg;
    addr_next = addr_reg;
    rd_addr_next = rd_addr_reg;
    out_sh_next = out_sh_reg;
    out_left_next = out_left_reg;
    io0_next = io0_reg;
    io1_next = io1_reg;
    io0_oe_n_next = io0_oe_n_reg;
    io1_oe_n_next = io1_oe_n_reg;
    wel_next = wel_reg;
    write_enable_cmd_go = 1'b0;
    write_disable_cmd_go = 1'b0;
    erase_go = 1'b0;
    if (cs_hi) begin
      rise_cnt_next = 6'h00;
      cmd_next = NO_CMD;
      out_left_next = 3'h0;
      io0_oe_n_next = 1'b1;
      io1_oe_n_next = 1'b1;
      if (cs_rise && rise_cnt_reg == `OPCODE_CLKS) begin
        write_disable_cmd_go = (cmd_reg == WRITE_DISABLE_CMD);
        write_enable_cmd_go = (cmd_reg == WRITE_ENABLE_CMD);
      end
      if (cs_rise && rise_cnt_reg == `ERASE_CLKS && wel_reg && !busy_reg &&
          (cmd_reg == SMALL_BLOCK_CLEAR_4K || cmd_reg == BLOCK_CLEAR_64K)) begin
        erase_go = 1'b1;
      end
    end else begin
      if (sck_rise) begin
        if (rise_cnt_reg != `RISE_CNT_MAX) begin
          rise_cnt_next = rise_cnt_reg + 6'h01;
        end
        if (rise_cnt_reg < `OPCODE_CLKS) begin
          op_sh_next = {op_sh_reg[5:0], bit0};
          if (rise_cnt_reg == `OPCODE_CLKS - 6'h01) begin
            cmd_next = decode_op({op_sh_reg, bit0});
          end
        end else if (cmd_reg == DUAL_ADDR_DATA_READ_CMD) begin
          if (rise_cnt_reg < `DUAL_ADDR_END) begin
            addr_next = {addr_reg[21:0], bit1, bit0};
            if (rise_cnt_reg == `DUAL_ADDR_END - 6'h01) begin
              rd_addr_next = {addr_reg[AW-3:0], bit1, bit0};
            end
          end
        end else if (rise_cnt_reg < `SINGLE_ADDR_END) begin
          addr_next = {addr_reg[22:0], bit0};
          if (rise_cnt_reg == `SINGLE_ADDR_END - 6'h01) begin
            rd_addr_next = {addr_reg[AW-2:0], bit0};
          end
        end
      end
      if (data_fall) begin
        if (load_ev) begin
          rd_addr_next = rd_addr_reg + AW'(1);
          io1_next = arr_if.rd_data[7];
          io1_oe_n_next = 1'b0;
          if (is_dual(cmd_reg)) begin
            io0_next = arr_if.rd_data[6];
            io0_oe_n_next = 1'b0;
            out_sh_next = {arr_if.rd_data[5:0], 2'b00};
            out_left_next = 3'h3;
          end else begin
            out_sh_next = {arr_if.rd_data[6:0], 1'b0};
            out_left_next = 3'h7;
          end
        end else begin
          out_left_next = out_left_reg - 3'h1;
          io1_next = out_sh_reg[7];
          if (is_dual(cmd_reg)) begin
            io0_next = out_sh_reg[6];
            out_sh_next = {out_sh_reg[5:0], 2'b00};
          end else begin
            out_sh_next = {out_sh_reg[6:0], 1'b0};
          end
        end
      end
    end
    // Set wins over completion clear
    if (write_disable_cmd_go) wel_next = 1'b0;
    if (er_last) wel_next = 1'b0;
    if (write_enable_cmd_go) wel_next = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_cnt_reg <= 6'h00;
      op_sh_reg <= 7'h00;
      cmd_reg <= NO_CMD;
      addr_reg <= 24'h000000;
      rd_addr_reg <= '0;
      out_sh_reg <= 8'h00;
      out_left_reg <= 3'h0;
      io0_reg <= 1'b0;
      io1_reg <= 1'b0;
      io0_oe_n_reg <= 1'b1;
      io1_oe_n_reg <= 1'b1;
      wel_reg <= 1'b0;
    end else begin
      rise_cnt_reg <= rise_cnt_next;
      op_sh_reg <= op_sh_next;
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      rd_addr_reg <= rd_addr_next;
      out_sh_reg <= out_sh_next;
      out_left_reg <= out_left_next;
      io0_reg <= io0_next;
      io1_reg <= io1_next;
      io0_oe_n_reg <= io0_oe_n_next;
      io1_oe_n_reg <= io1_oe_n_next;
      wel_reg <= wel_next;
    end
  end

  // Erase engine: one byte cleared per cycle acts as the internal timer
  erase_state_e er_state_reg, er_state_next;
  logic [AW-1:0] er_addr_reg, er_addr_next;
  logic [LW-1:0] er_left_reg, er_left_next;
  logic clr_en;
  logic big_clear;
  assign big_clear = (cmd_reg == BLOCK_CLEAR_64K);

  always_comb begin
    er_state_next = er_state_reg;
    er_addr_next = er_addr_reg;
    er_left_next = er_left_reg;
    busy_next = busy_reg;
    clr_en = 1'b0;
    er_last = 1'b0;
    case (er_state_reg)
      ER_IDLE: begin
        if (erase_go) begin
          er_state_next = ER_RUN;
          busy_next = 1'b1;
          if (big_clear) begin
            er_addr_next = addr_reg[AW-1:0] & ~BLOCK_MASK;
            er_left_next = LW'(BLOCK_BYTES - 1);
          end else begin
            er_addr_next = addr_reg[AW-1:0] & ~SMALL_MASK;
            er_left_next = LW'(SMALL_BYTES - 1);
          end
        end
      end
      ER_RUN: begin
        clr_en = 1'b1;
        er_addr_next = er_addr_reg + AW'(1);
        if (er_left_reg == '0) begin
          er_last = 1'b1;
          busy_next = 1'b0;
          er_state_next = ER_IDLE;
        end else begin
          er_left_next = er_left_reg - LW'(1);
        end
      end
      default: er_state_next = ER_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      er_state_reg <= ER_IDLE;
      er_addr_reg <= '0;
      er_left_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      er_state_reg <= er_state_next;
      er_addr_reg <= er_addr_next;
      er_left_reg <= er_left_next;
      busy_reg <= busy_next;
    end
  end

  assign arr_if.rd_addr = rd_addr_reg;
  assign arr_if.clr_en = clr_en;
  assign arr_if.clr_addr = er_addr_reg;

  // Pins come straight from flops; no pin is driven outside a data phase
  assign io0_o = io0_reg;
  assign io1_o = io1_reg;
  assign io0_oe_n_o = io0_oe_n_reg;
  assign io1_oe_n_o = io1_oe_n_reg;
  assign busy_o = busy_reg;
  assign wel_o = wel_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_deselect_release: assert property (cs_hi |=> io0_oe_n_o && io1_oe_n_o)
    else $error("pins driven while deselected");
  a_write_disable_cmd_clears_wel: assert property (write_disable_cmd_go && !write_enable_cmd_go |=> !wel_o)
    else $error("write disable left latch set");
  a_lp_first_bit: assert property (load_ev && cmd_reg == LOW_POWER_READ_CMD &&
    rise_cnt_reg == `LOW_POWER_HDR |=> !io1_oe_n_o && io0_oe_n_o &&
    io1_o === $past(arr_if.rd_data[7]))
    else $error("low-power read first bit wrong");
  a_fast_first_bit: assert property (load_ev && cmd_reg == FAST_READ_CMD
    |-> rise_cnt_reg >= `FAST_HDR)
    else $error("fast read data before dummy byte ended");
  a_dio_turnaround: assert property (load_ev && cmd_reg == DUAL_ADDR_DATA_READ_CMD
    |-> rise_cnt_reg >= `DUAL_IO_HDR)
    else $error("dual IO data before clock 23 fall");
  // Unerased bytes read as unknown, so the lanes are matched case-exact
  a_dual_bit_map: assert property (load_ev && is_dual(cmd_reg) |=>
    io1_o === $past(arr_if.rd_data[7]) && io0_o === $past(arr_if.rd_data[6]) && !io0_oe_n_o)
    else $error("dual lane mapping wrong");
  a_addr_wrap_step: assert property (load_ev |=> rd_addr_reg == $past(rd_addr_reg) + AW'(1))
    else $error("read address did not step");
  a_dual_byte_len: assert property (load_ev && is_dual(cmd_reg) |=> out_left_reg == 3'h3)
    else $error("dual byte not four clocks");
  a_erase_gate: assert property (erase_go |-> wel_reg && rise_cnt_reg == `ERASE_CLKS)
    else $error("erase started without latch or full address");
  a_erase_start: assert property (erase_go |=> busy_o ##1 clr_en)
    else $error("erase did not start");
  a_erase_align: assert property (erase_go && !big_clear |=> er_addr_reg[11:0] == 12'h000)
    else $error("small clear not aligned");
  a_erase_end_wel: assert property (er_last && !write_enable_cmd_go |=> !wel_o && !busy_o)
    else $error("erase end left latch or busy set");
  a_sample_rise_only: assert property (!sck_rise && !cs_hi |=> $stable(op_sh_reg))
    else $error("opcode shifted without rising edge");

  c_lp_read: cover property (load_ev && cmd_reg == LOW_POWER_READ_CMD);
  c_dio_read: cover property (load_ev && cmd_reg == DUAL_ADDR_DATA_READ_CMD);
  c_erase_done: cover property (er_last);
  c_write_disable_cmd: cover property (write_disable_cmd_go);
endmodule

// *** include/flash_cmd_map.svh ***
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
// Opcodes on the serial line
`define OP_WRITE_DISABLE 8'h04
`define OP_WRITE_ENABLE 8'h06
`define OP_LOW_POWER_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_DUAL_OUT_READ 8'h3B
`define OP_DUAL_IO_READ 8'hBB
`define OP_CLEAR_4K_A 8'h20
`define OP_CLEAR_4K_B 8'hD7
`define OP_CLEAR_64K 8'hD8
// Rising-edge counts that close each phase
`define OPCODE_CLKS 6'h08
`define SINGLE_ADDR_END 6'h20
`define DUAL_ADDR_END 6'h14
`define LOW_POWER_HDR 6'h20
`define FAST_HDR 6'h28
`define DUAL_IO_HDR 6'h18
`define ERASE_CLKS 6'h20
`define RISE_CNT_MAX 6'h3F
// Array geometry and erased value
`define MEM_AW 20
`define SMALL_BLOCK_BYTES 4096
`define BLOCK_BYTES 65536
`define ERASED_BYTE 8'hFF
`endif

// *** include/flash_seq_pkg.sv ***
package flash_seq_pkg;
  // Decoded command of the current frame
  typedef enum logic [3:0] {
    NO_CMD = 4'h0,
    WRITE_DISABLE_CMD = 4'h1,
    WRITE_ENABLE_CMD = 4'h2,
    LOW_POWER_READ_CMD = 4'h3,
    FAST_READ_CMD = 4'h4,
    DUAL_OUTPUT_READ_CMD = 4'h5,
    DUAL_ADDR_DATA_READ_CMD = 4'h6,
    SMALL_BLOCK_CLEAR_4K = 4'h7,
    BLOCK_CLEAR_64K = 4'h8,
    UNKNOWN_CMD = 4'hF
  } cmd_e;
  // Erase engine states
  typedef enum logic [0:0] {
    ER_IDLE = 1'b0,
    ER_RUN = 1'b1
  } erase_state_e;
endpackage

// *** include/array_if.sv ***
`timescale 1ns/100ps
// Read and clear port between sequencer and byte array
interface array_if #(parameter int AW = 20);
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic clr_en;
  logic [AW-1:0] clr_addr;
  modport ctrl (output rd_addr, output clr_en, output clr_addr, input rd_data);
  modport mem (input rd_addr, input clr_en, input clr_addr, output rd_data);
endinterface

// *** rtl/flash_byte_array.sv ***
`timescale 1ns/100ps
`include "flash_cmd_map.svh"
module flash_byte_array #(
  parameter int AW = `MEM_AW
) (
  input wire logic clk_i,
  array_if.mem port_if
);
  logic [7:0] mem_reg [0:(1<<AW)-1];
  logic [7:0] rd_data_reg;

  // One clear per cycle; read has one cycle of latency
  always_ff @(posedge clk_i) begin
    if (port_if.clr_en) begin
      mem_reg[port_if.clr_addr] <= `ERASED_BYTE;
    end
    rd_data_reg <= mem_reg[port_if.rd_addr];
  end

  assign port_if.rd_data = rd_data_reg;
endmodule

// *** sim/spi_host_model.sv ***
`timescale 1ns/100ps
// Behavioural SPI host, mode 0: SCK idles low and only runs inside frames
module spi_host_model (
  output logic cs_n_o,
  output logic sck_o,
  output logic io0_o,
  output logic io0_oe_n_o,
  output logic io1_o,
  output logic io1_oe_n_o,
  input wire logic io0_i,
  input wire logic io1_i
);
  // Half of the 125 ns link period
  localparam realtime HALF = 62.5;

  // Idle: deselected, only the single input line driven
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    io0_o = 1'b0;
    io0_oe_n_o = 1'b0;
    io1_o = 1'b0;
    io1_oe_n_o = 1'b1;
  end

  task automatic open_frame();
    cs_n_o = 1'b0;
    #(HALF);
  endtask

  // Deselect, wait out the device release, then take line zero back
  task automatic close_frame();
    #(HALF);
    cs_n_o = 1'b1;
    #(HALF);
    io0_oe_n_o = 1'b0;
    io1_oe_n_o = 1'b1;
    #(HALF);
  endtask

  // data set up while SCK low, taken on the rise
  task automatic tick(input logic b1, input logic b0);
    io1_o = b1;
    io0_o = b0;
    #(HALF);
    sck_o = 1'b1;
    #(HALF);
    sck_o = 1'b0;
  endtask

  // one byte MSB first on the single line
  task automatic send8(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) tick(1'b0, v[i]);
  endtask

  // opcode and 24-bit address as one word
  task automatic send32(input logic [31:0] v);
    for (int i = 31; i >= 0; i--) tick(1'b0, v[i]);
  endtask

  // odd address bits on line one, even ones on line zero
  task automatic send_dual_addr(input logic [23:0] a);
    io1_oe_n_o = 1'b0;
    for (int i = 11; i >= 0; i--) tick(a[2*i+1], a[2*i]);
    // two driven dummies, then both lines released
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b1);
    io0_oe_n_o = 1'b1;
    io1_oe_n_o = 1'b1;
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
  endtask

  // hand line zero to the device for dual output data
  task automatic release_lines();
    io0_oe_n_o = 1'b1;
    io1_oe_n_o = 1'b1;
  endtask

  // Sample late in the low phase, long after the device has settled
  task automatic rd_byte(input logic dual, output logic [7:0] b);
    int n;
    n = dual ? 4 : 8;
    for (int i = 0; i < n; i++) begin
      #(HALF);
      if (dual) b = {b[5:0], io1_i, io0_i};
      else b = {b[6:0], io1_i};
      sck_o = 1'b1;
      #(HALF);
      sck_o = 1'b0;
    end
  endtask
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`include "flash_cmd_map.svh"
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sck, h_io0, h_oe0_n, h_io1, h_oe1_n;
  logic d_io0, d_oe0_n, d_io1, d_oe1_n, busy, wel;
  logic fill = 1'b0;
  wire logic line0, line1;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int busy_len = 0;

  // 100 MHz system clock
  always #5 clk = ~clk;

  // Undriven lines toggle so a stale value is never mistaken for data
  always @(posedge clk) fill <= ~fill;
  assign line0 = !d_oe0_n ? d_io0 : (!h_oe0_n ? h_io0 : fill);
  assign line1 = !d_oe1_n ? d_io1 : (!h_oe1_n ? h_io1 : ~fill);

  // Busy length restarts in each idle frame; hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) busy_len <= busy_len + 1;
    else if (cs_n === 1'b0) busy_len <= 0;
    if (cycles == 99000) begin
      n_fail++;
      close_out();
    end
  end

  serial_flash_read_erase_cmds u_serial_flash_read_erase_cmds (
    .clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .sck_i(sck),
    .io0_i(line0), .io0_o(d_io0), .io0_oe_n_o(d_oe0_n),
    .io1_i(line1), .io1_o(d_io1), .io1_oe_n_o(d_oe1_n),
    .busy_o(busy), .wel_o(wel)
  );

  spi_host_model u_spi_host_model (
    .cs_n_o(cs_n), .sck_o(sck), .io0_o(h_io0), .io0_oe_n_o(h_oe0_n),
    .io1_o(h_io1), .io1_oe_n_o(h_oe1_n), .io0_i(line0), .io1_i(line1)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic eq);
    comparisons++;
    if ((got === exp) !== eq) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %s%h", $time, got, eq ? "" : "not ", exp);
    end
  endtask

  task automatic one_op(input logic [7:0] op);
    u_spi_host_model.open_frame();
    u_spi_host_model.send8(op);
    u_spi_host_model.close_frame();
  endtask

  // Latch set and clear, erase refused without latch or full address
  task automatic t_latch();
    one_op(`OP_WRITE_ENABLE);
    chk(wel, 1, 1);
    one_op(`OP_WRITE_DISABLE);
    chk(wel, 0, 1);
    u_spi_host_model.open_frame();
    u_spi_host_model.send32({`OP_CLEAR_64K, 24'h000000});
    u_spi_host_model.close_frame();
    chk(busy, 0, 1);
    one_op(`OP_WRITE_ENABLE);
    u_spi_host_model.open_frame();
    u_spi_host_model.send8(`OP_CLEAR_4K_A);
    u_spi_host_model.send8(8'h00);
    u_spi_host_model.close_frame();
    chk({busy, wel}, 2'b01, 1);
    one_op(`OP_WRITE_DISABLE);
  endtask

  // Erase runs on its own from the deselect, then drops the latch
  task automatic t_erase(input logic [7:0] op, input logic [23:0] a, input int len);
    one_op(`OP_WRITE_ENABLE);
    u_spi_host_model.open_frame();
    u_spi_host_model.send32({op, a});
    u_spi_host_model.close_frame();
    chk(busy, 1, 1);
    // Look just after the edge so busy has settled
    for (int k = 0; k < 70000 && busy !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    chk(busy_len, len, 1);
    chk(wel, 0, 1);
  endtask

  // Two-byte read; second byte crosses into the next address
  task automatic t_read(input logic [7:0] op, input logic [23:0] a,
                        input logic e0, input logic e1);
    logic dual;
    logic [7:0] b0, b1;
    dual = (op == `OP_DUAL_OUT_READ) || (op == `OP_DUAL_IO_READ);
    u_spi_host_model.open_frame();
    if (op == `OP_DUAL_IO_READ) begin
      u_spi_host_model.send8(op);
      u_spi_host_model.send_dual_addr(a);
    end else begin
      u_spi_host_model.send32({op, a});
      if (op != `OP_LOW_POWER_READ) u_spi_host_model.send8(8'h00);
    end
    if (op == `OP_DUAL_OUT_READ) u_spi_host_model.release_lines();
    chk({d_oe1_n, d_oe0_n}, 2'b11, 1);
    u_spi_host_model.rd_byte(dual, b0);
    chk(d_oe1_n, 0, 1);
    chk(d_oe0_n, !dual, 1);
    u_spi_host_model.rd_byte(dual, b1);
    u_spi_host_model.close_frame();
    chk(b0, 8'hFF, e0);
    chk(b1, 8'hFF, e1);
    chk({d_oe1_n, d_oe0_n}, 2'b11, 1);
  endtask

  task automatic close_out();
    $display("counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    t_latch();
    // Top nibble of the address is ignored; one byte cleared per clock
    t_erase(`OP_CLEAR_4K_A, 24'h3FF800, `SMALL_BLOCK_BYTES);
    t_erase(`OP_CLEAR_4K_B, 24'h000FFF, `SMALL_BLOCK_BYTES);
    t_erase(`OP_CLEAR_64K, 24'h01ABCD, `BLOCK_BYTES);
    t_read(`OP_LOW_POWER_READ, 24'h0FFFFF, 1, 1);
    t_read(`OP_FAST_READ, 24'h000FFF, 1, 0);
    t_read(`OP_DUAL_OUT_READ, 24'h00FFFF, 0, 1);
    t_read(`OP_DUAL_IO_READ, 24'h01FFFF, 1, 0);
    close_out();
  end
endmodule
